/* File: rtl/pcs_pkg.sv */
package pcs_pkg;

    // ------------------------------------------------------------------
    // Widths and constants
    // ------------------------------------------------------------------
    localparam int unsigned CUR_W = 16;
    localparam int unsigned DLY_W = 16;
    localparam int unsigned SEC_W = 3;
    localparam logic [SEC_W-1:0] SEC_MIN = 3'h1;
    localparam logic [SEC_W-1:0] SEC_MAX = 3'h6;
    localparam logic [SEC_W-1:0] SEC_RESET = 3'h1;
    localparam logic [DLY_W-1:0] DLY_ZERO = 16'h0000;
    localparam logic [DLY_W-1:0] DLY_ONE = 16'h0001;
    localparam logic signed [CUR_W-1:0] CUR_ZERO = 16'sh0000;

    typedef enum logic [2:0] {
        PCS_PH_A = 3'b001,
        PCS_PH_B = 3'b010,
        PCS_PH_C = 3'b100
    } pcs_phase_t;

    typedef struct packed {
        logic signed [CUR_W-1:0] ia;
        logic signed [CUR_W-1:0] ib;
        logic signed [CUR_W-1:0] ic;
    } pcs_currents_t;

    typedef struct packed {
        logic signed [CUR_W-1:0] first;
        logic signed [CUR_W-1:0] second;
    } pcs_adc_pair_t;

endpackage : pcs_pkg

/* File: rtl/pcs_sampler.sv */
`timescale 1ns/100ps
module pcs_sampler
    import pcs_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic pwm_reload_i,
    input wire logic load_ok_bit_i,
    input wire logic [DLY_W-1:0] trig_delay_i,
    input wire logic [DLY_W-1:0] bottom_on_time_i,
    input wire logic [DLY_W-1:0] critical_width_i,
    input wire logic svm_sector_sel_i,
    input wire logic [SEC_W-1:0] svm_sector_i,
    input wire logic [SEC_W-1:0] sine_sector_i,
    input wire logic adc_done_i,
    input wire pcs_adc_pair_t adc_pair_i,
    output logic sync_pulse_o,
    output logic adc_start_o,
    output logic [SEC_W-1:0] sector_o,
    output pcs_phase_t calc_phase_o,
    output pcs_currents_t currents_o,
    output logic currents_valid_o,
    output logic sample_unreliable_o
);

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    function automatic pcs_phase_t phase_of(input logic [SEC_W-1:0] s);
        if (s == 3'h2 || s == 3'h3) begin
            phase_of = PCS_PH_B;
        end else if (s == 3'h4 || s == 3'h5) begin
            phase_of = PCS_PH_C;
        end else begin
            phase_of = PCS_PH_A;
        end
    endfunction : phase_of

    // The sum saturates rather than wraps so a clipped sample stays sane.
    function automatic logic signed [CUR_W-1:0] neg_sum(input logic signed [CUR_W-1:0] x,
                                                        input logic signed [CUR_W-1:0] y);
        logic signed [CUR_W+1:0] t;
        t = -({{2{x[CUR_W-1]}}, x} + {{2{y[CUR_W-1]}}, y});
        if (t > $signed({3'b000, {(CUR_W-1){1'b1}}})) begin
            neg_sum = {1'b0, {(CUR_W-1){1'b1}}};
        end else if (t < $signed({3'b111, {(CUR_W-1){1'b0}}})) begin
            neg_sum = {1'b1, {(CUR_W-1){1'b0}}};
        end else begin
            neg_sum = t[CUR_W-1:0];
        end
    endfunction : neg_sum

    // ------------------------------------------------------------------
    // Reload sync and delay timer
    // ------------------------------------------------------------------
    logic reload_q, reload_d;
    logic sync_q, sync_d;
    logic run_q, run_d;
    logic [DLY_W-1:0] cnt_q, cnt_d;
    logic start_q, start_d;
    logic unrel_q, unrel_d;
    logic [SEC_W-1:0] sec_q, sec_d;
    logic [SEC_W-1:0] sec_in;

    always_comb begin
        reload_d = pwm_reload_i;
        // The load-ok bit is ignored on purpose; every reload edge syncs.
        sync_d = pwm_reload_i && !reload_q;
        run_d = run_q;
        cnt_d = cnt_q;
        start_d = 1'b0;
        sec_d = sec_q;
        unrel_d = unrel_q;
        sec_in = svm_sector_sel_i ? svm_sector_i : sine_sector_i;
        if (sync_q) begin
            // A fresh pulse restarts the count even mid-delay.
            run_d = 1'b1;
            cnt_d = trig_delay_i;
            // Latch per-period context at the reload so it matches the sample.
            if (sec_in >= SEC_MIN && sec_in <= SEC_MAX) begin
                sec_d = sec_in;
            end
            unrel_d = bottom_on_time_i < critical_width_i;
        end else if (run_q) begin
            if (cnt_q == DLY_ZERO) begin
                run_d = 1'b0;
                start_d = 1'b1;
            end else begin
                cnt_d = cnt_q - DLY_ONE;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            reload_q <= 1'b0;
            sync_q <= 1'b0;
            run_q <= 1'b0;
            cnt_q <= DLY_ZERO;
            start_q <= 1'b0;
            sec_q <= SEC_RESET;
            unrel_q <= 1'b0;
        end else begin
            reload_q <= reload_d;
            sync_q <= sync_d;
            run_q <= run_d;
            cnt_q <= cnt_d;
            start_q <= start_d;
            sec_q <= sec_d;
            unrel_q <= unrel_d;
        end
    end

    // ------------------------------------------------------------------
    // Third-current reconstruction
    // ------------------------------------------------------------------
    pcs_currents_t cur_q, cur_d;
    logic val_q, val_d;
    logic rel_q, rel_d;
    pcs_phase_t ph_q, ph_d;

    always_comb begin
        cur_d = cur_q;
        val_d = 1'b0;
        rel_d = rel_q;
        ph_d = phase_of(sec_q);
        if (adc_done_i) begin
            val_d = 1'b1;
            rel_d = unrel_q;
            // Pair order: A,B,C minus the computed phase, ascending.
            case (phase_of(sec_q))
                PCS_PH_A: begin
                    cur_d.ib = adc_pair_i.first;
                    cur_d.ic = adc_pair_i.second;
                    cur_d.ia = neg_sum(adc_pair_i.first, adc_pair_i.second);
                end
                PCS_PH_B: begin
                    cur_d.ia = adc_pair_i.first;
                    cur_d.ic = adc_pair_i.second;
                    cur_d.ib = neg_sum(adc_pair_i.first, adc_pair_i.second);
                end
                default: begin
                    cur_d.ia = adc_pair_i.first;
                    cur_d.ib = adc_pair_i.second;
                    cur_d.ic = neg_sum(adc_pair_i.first, adc_pair_i.second);
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            cur_q <= '{CUR_ZERO, CUR_ZERO, CUR_ZERO};
            val_q <= 1'b0;
            rel_q <= 1'b0;
            ph_q <= PCS_PH_A;
        end else begin
            cur_q <= cur_d;
            val_q <= val_d;
            rel_q <= rel_d;
            ph_q <= ph_d;
        end
    end

    assign sync_pulse_o = sync_q;
    assign adc_start_o = start_q;
    assign sector_o = sec_q;
    assign calc_phase_o = ph_q;
    assign currents_o = cur_q;
    assign currents_valid_o = val_q;
    assign sample_unreliable_o = rel_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_sync_then_quiet;
        sync_pulse_o ##1 !sync_pulse_o;
    endsequence

    a_sync_one_cycle: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        sync_pulse_o |-> s_sync_then_quiet)
        else $error("Sync pulse longer than one cycle.");

    a_sync_on_reload: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (pwm_reload_i && !$past(pwm_reload_i)) |=> sync_pulse_o)
        else $error("Reload did not produce a sync pulse.");

    a_delay_zero_start: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (sync_pulse_o && trig_delay_i == DLY_ZERO) ##1 !sync_pulse_o |=> adc_start_o)
        else $error("Zero delay did not start conversion after two cycles.");

    a_start_needs_sync: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        adc_start_o |-> $past(run_q) && !$past(sync_pulse_o))
        else $error("Conversion started without an armed timer.");

    a_timer_restart: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        sync_pulse_o |=> run_q && cnt_q == $past(trig_delay_i))
        else $error("Delay timer did not reload on sync.");

    a_sector_range: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        sector_o >= SEC_MIN && sector_o <= SEC_MAX)
        else $error("Sector out of range.");

    a_sum_zero: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        currents_valid_o && !(adc_pair_i.first == CUR_ZERO) && $past(adc_done_i)
        && ($past(adc_pair_i.first) + $past(adc_pair_i.second) < 17'sh4000)
        && ($past(adc_pair_i.first) + $past(adc_pair_i.second) > -17'sh4000)
        |-> (CUR_W + 2)'(currents_o.ia + currents_o.ib + currents_o.ic) == '0)
        else $error("Phase currents do not sum to zero.");

    a_sector_a_calc: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (adc_done_i && (sector_o == 3'h1 || sector_o == 3'h6))
        |=> currents_o.ib == $past(adc_pair_i.first)
        && currents_o.ic == $past(adc_pair_i.second))
        else $error("Sectors 1 and 6 must compute phase A.");

    a_unreliable_flag: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        adc_done_i |=> sample_unreliable_o == $past(unrel_q))
        else $error("Unreliable flag does not follow conduction check.");

    a_unrel_latch: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        sync_pulse_o |=> unrel_q == ($past(bottom_on_time_i) < $past(critical_width_i)))
        else $error("Conduction check not latched on sync.");

endmodule : pcs_sampler

/* File: tb/pcs_far_end_model.sv */
`timescale 1ns/100ps
module pcs_far_end_model
    import pcs_pkg::*;
(
    input wire logic clk_i,
    input wire logic adc_start_i,
    input wire logic [3:0] lat_i,
    input wire pcs_adc_pair_t pair_i,
    output logic adc_done_o,
    output pcs_adc_pair_t adc_pair_o
);
    // ------------------------------------------------------------------
    // Converter stand-in
    // ------------------------------------------------------------------
    // Outside the done cycle the result lines toggle, so a stale read shows.
    logic [3:0] cnt_q = 4'h0;
    initial adc_done_o = 1'b0;
    initial adc_pair_o = '0;
    always @(negedge clk_i) begin
        adc_done_o <= 1'b0;
        adc_pair_o <= ~adc_pair_o;
        if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
            if (cnt_q == 4'h1) begin
                adc_done_o <= 1'b1;
                adc_pair_o <= pair_i;
            end
        end else if (adc_start_i) begin
            cnt_q <= lat_i;
        end
    end
endmodule : pcs_far_end_model

/* File: tb/pcs_sampler_tb.sv */
`timescale 1ns/100ps
module pcs_sampler_tb
    import pcs_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, rel = 1'b0, lok = 1'b0, ssel = 1'b0, done;
    logic [DLY_W-1:0] dly = 16'h0002, bot = 16'h0006, crit = 16'h0006;
    logic [SEC_W-1:0] svm = 3'h1, sine = 3'h1, sec;
    logic sync, start, valid, unrel;
    pcs_adc_pair_t pair;
    pcs_phase_t ph;
    pcs_currents_t cur;
    int err_total = 0, n_tests = 0;
    initial forever #20 clk = ~clk;
    pcs_far_end_model far (.clk_i(clk), .adc_start_i(start), .lat_i(4'h3),
        .pair_i({16'sh0100, 16'sh0023}), .adc_done_o(done), .adc_pair_o(pair));
    pcs_sampler DUT (.clk_sys_i(clk), .resetn_i(rst_n), .pwm_reload_i(rel),
        .load_ok_bit_i(lok), .trig_delay_i(dly), .bottom_on_time_i(bot),
        .critical_width_i(crit), .svm_sector_sel_i(ssel), .svm_sector_i(svm),
        .sine_sector_i(sine), .adc_done_i(done), .adc_pair_i(pair),
        .sync_pulse_o(sync), .adc_start_o(start), .sector_o(sec),
        .calc_phase_o(ph), .currents_o(cur), .currents_valid_o(valid),
        .sample_unreliable_o(unrel));
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic reload();
        @(negedge clk) rel = 1'b1;
        @(negedge clk) rel = 1'b0;
    endtask : reload
    task automatic wait_hi(input int sel, output int n);
        // The level is tested before waiting, since reload returns while sync stands.
        n = 0;
        while (!(sel == 0 ? sync === 1'b1 : sel == 1 ? start === 1'b1 : valid === 1'b1)
            && n < 60) begin
            @(negedge clk);
            n++;
        end
        if (n >= 60) err_total++;
    endtask : wait_hi
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    int n2, n6;
    task automatic t_delay();
        int n;
        dly = 16'h0002;
        lok = 1'b0;
        reload();
        wait_hi(0, n);
        @(negedge clk) chk(sync, 1'b0);
        wait_hi(1, n2);
        dly = 16'h0006;
        lok = 1'b1;
        reload();
        wait_hi(0, n);
        chk(n < 60, 1'b1);
        wait_hi(1, n6);
        // The first count starts one cycle after the pulse, the second on it.
        chk(n2, 16'h0003);
        chk(n6, 16'h0008);
        chk(n6 - n2, 16'h0005);
    endtask : t_delay
    task automatic t_restart();
        int n;
        reload();
        wait_hi(0, n);
        repeat (2) @(negedge clk);
        reload();
        wait_hi(0, n);
        wait_hi(1, n);
        chk(n, n6);
    endtask : t_restart
    task automatic t_sectors();
        int n;
        logic [SEC_W-1:0] s;
        pcs_currents_t e;
        dly = 16'h0000;
        for (int i = 1; i <= 6; i++) begin
            s = SEC_W'(i);
            ssel = s[0];
            // The unused source holds a sector of another group.
            svm = ssel ? s : SEC_W'(((i + 1) % 6) + 1);
            sine = ssel ? SEC_W'(((i + 1) % 6) + 1) : s;
            bot = (i == 3) ? 16'h0005 : 16'h0006;
            e = (i == 1 || i == 6) ? {16'hFEDD, 16'h0100, 16'h0023} :
                (i < 4) ? {16'h0100, 16'hFEDD, 16'h0023} : {16'h0100, 16'h0023, 16'hFEDD};
            reload();
            wait_hi(2, n);
            chk(sec, s);
            chk(ph, (i == 1 || i == 6) ? PCS_PH_A : (i < 4) ? PCS_PH_B : PCS_PH_C);
            chk(cur, e);
            chk(unrel, i == 3);
        end
        svm = 3'h7;
        sine = 3'h7;
        reload();
        wait_hi(0, n);
        @(negedge clk) chk(sec, 3'h6);
    endtask : t_sectors
    // ------------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------------
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish
    initial begin
        #(40 * 3000);
        err_total++;
        tally_and_finish();
    end
    initial begin
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        chk({sec, ph}, {3'h1, PCS_PH_A});
        t_delay();
        t_restart();
        t_sectors();
        tally_and_finish();
    end
endmodule : pcs_sampler_tb
